//--- verilog/bus_front_pkg.sv
// Package with constants and mode types for the bus front end
package bus_front_pkg;
  // Oscillator cycles per bus clock
  localparam int unsigned OSC_PER_BUS = 4;
  // Half of a bus period in oscillator ticks
  localparam logic [1:0] HALF_TICKS = 2'h2;
  // Top address of the on-chip RAM window
  localparam logic [15:0] RAM_TOP_ADDR = 16'h007f;
  // Offset added to the program counter in relative mode
  localparam logic [7:0] REL_BIAS = 8'h02;
  // Number of on-chip RAM words
  localparam int unsigned RAM_WORDS = 128;
  // Reset values
  localparam logic [1:0] PHASE_RST = 2'h0;
  localparam logic [15:0] ADDR_RST = 16'hffff;
  // Addressing modes of an operand request
  typedef enum logic [2:0] {
    MODE_ACCUM = 3'b000,
    MODE_IMMED = 3'b001,
    MODE_DIRECT = 3'b010,
    MODE_EXTEND = 3'b011,
    MODE_INDEX = 3'b100,
    MODE_IMPLIED = 3'b101,
    MODE_RELATIVE = 3'b110
  } addr_mode_t;
endpackage

//--- verilog/ram_store.sv
// Small on-chip RAM with registered read data
`timescale 1ns/1ps
module ram_store #(
  parameter int unsigned WORDS = 128,
  parameter int unsigned AW = 7
) (
  input wire logic clk_in,
  input wire logic we_in,
  input wire logic [AW-1:0] addr_in,
  input wire logic [7:0] wdata_in,
  output logic [7:0] rdata_out
);
  logic [7:0] mem_q [WORDS];
  // Write port and registered read port
  always_ff @(posedge clk_in) begin
    if (we_in) begin
      mem_q[addr_in] <= wdata_in;
    end
    rdata_out <= mem_q[addr_in];
  end
endmodule

//--- verilog/bus_front.sv
// Bus clock generator, stretch control, RAM gating and operand address unit
//
// Summary of operation
// - RAM writes only while select is high; reads use select sampled at cycle start
// - Bus clock is oscillator divided by four
// - Hold low stretches clock by half periods
// - Single-phase bus clock output, stretchable
// - Accumulator mode has no memory address
// - Immediate operand at following byte address
// - Direct address has zero upper byte
// - Extended address is second then third byte
// - Indexed adds unsigned byte with carry
// - Indexed result in temp, index unchanged
// - Relative adds signed byte to PC plus two
// - Implied mode has no memory address
// - Low 128 addresses hit on-chip RAM
`timescale 1ns/1ps
module bus_front
  import bus_front_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic slow_memory_hold_input,
  input wire logic ram_select_input,
  input wire logic req_in,
  input wire logic [2:0] mode_in,
  input wire logic [7:0] byte2_in,
  input wire logic [7:0] byte3_in,
  input wire logic [15:0] pc_in,
  input wire logic [15:0] index_in,
  input wire logic rw_in,
  input wire logic [7:0] wdata_in,
  output logic bus_clk_out,
  output logic [15:0] addr_out,
  output logic rw_out,
  output logic mem_access_out,
  output logic ram_hit_out,
  output logic data_drive_n_out,
  output logic [7:0] rdata_out,
  output logic [15:0] temp_addr_out,
  output logic cycle_end_out
);
  // Synchroniser stages for the pin inputs
  logic hold_s1_q, hold_s2_q;
  logic rsel_s1_q, rsel_s2_q;
  // Bus clock phase counter and stretch state
  logic [1:0] tick_q, tick_d;
  logic bus_clk_q, bus_clk_d;
  logic end_q, end_d;
  // Address unit state
  logic [15:0] addr_q, addr_d;
  logic [15:0] temp_q, temp_d;
  logic rw_q, rw_d;
  logic acc_q, acc_d;
  logic hit_q, hit_d;
  logic drv_n_q, drv_n_d;
  logic [7:0] wd_q, wd_d;
  logic ram_we;
  logic [7:0] ram_rd;

  // Indexed sum: low byte add, carry into high byte
  function automatic logic [15:0] idx_sum(input logic [15:0] base,
                                          input logic [7:0] off);
    logic [8:0] lo;
    lo = {1'b0, base[7:0]} + {1'b0, off};
    idx_sum = {base[15:8] + {7'h00, lo[8]}, lo[7:0]};
  endfunction

  // Relative sum: PC plus two plus signed offset
  function automatic logic [15:0] rel_sum(input logic [15:0] pc,
                                          input logic [7:0] off);
    logic [15:0] base;
    base = pc + {8'h00, REL_BIAS};
    rel_sum = base + {{8{off[7]}}, off};
  endfunction

  // Two-flop synchronisers for hold and select pins
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      hold_s1_q <= 1'b1;
      hold_s2_q <= 1'b1;
      rsel_s1_q <= 1'b0;
      rsel_s2_q <= 1'b0;
    end else begin
      hold_s1_q <= slow_memory_hold_input;
      hold_s2_q <= hold_s1_q;
      rsel_s1_q <= ram_select_input;
      rsel_s2_q <= rsel_s1_q;
    end
  end

  // Divide-by-four clock with stretch at the high phase end
  always_comb begin
    tick_d = tick_q;
    bus_clk_d = bus_clk_q;
    end_d = 1'b0;
    if (bus_clk_q && tick_q == 2'h3 && !hold_s2_q) begin
      // Hold low: extend by a half period of two ticks
      tick_d = HALF_TICKS;
    end else begin
      tick_d = tick_q + 2'h1;
      bus_clk_d = (tick_d >= HALF_TICKS);
      end_d = (tick_q == 2'h3);
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      tick_q <= PHASE_RST;
      bus_clk_q <= 1'b0;
      end_q <= 1'b0;
    end else begin
      tick_q <= tick_d;
      bus_clk_q <= bus_clk_d;
      end_q <= end_d;
    end
  end

  // Operand address formation, loaded only at cycle start
  always_comb begin
    addr_d = addr_q;
    temp_d = temp_q;
    rw_d = rw_q;
    acc_d = acc_q;
    hit_d = hit_q;
    drv_n_d = drv_n_q;
    wd_d = wd_q;
    // New request only when a bus cycle begins
    if (end_q) begin
      acc_d = 1'b0;
      rw_d = 1'b1;
      if (req_in) begin
        acc_d = 1'b1;
        rw_d = rw_in;
        wd_d = wdata_in;
        unique case (addr_mode_t'(mode_in))
          MODE_ACCUM, MODE_IMPLIED: begin
            acc_d = 1'b0;
          end
          MODE_IMMED: begin
            addr_d = pc_in + 16'h0001;
          end
          MODE_DIRECT: begin
            addr_d = {8'h00, byte2_in};
          end
          MODE_EXTEND: begin
            addr_d = {byte2_in, byte3_in};
          end
          MODE_INDEX: begin
            temp_d = idx_sum(index_in, byte2_in);
            addr_d = temp_d;
          end
          MODE_RELATIVE: begin
            addr_d = rel_sum(pc_in, byte2_in);
          end
          default: begin
            acc_d = 1'b0;
          end
        endcase
      end
      // RAM window decode gated by select
      hit_d = acc_d && addr_d <= RAM_TOP_ADDR && rsel_s2_q;
      drv_n_d = !(hit_d && rw_d);
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      addr_q <= ADDR_RST;
      temp_q <= 16'h0000;
      rw_q <= 1'b1;
      acc_q <= 1'b0;
      hit_q <= 1'b0;
      drv_n_q <= 1'b1;
      wd_q <= 8'h00;
    end else begin
      addr_q <= addr_d;
      temp_q <= temp_d;
      rw_q <= rw_d;
      acc_q <= acc_d;
      hit_q <= hit_d;
      drv_n_q <= drv_n_d;
      wd_q <= wd_d;
    end
  end

  // Write at the last tick of the cycle, only when selected
  assign ram_we = hit_q && !rw_q && end_d && rsel_s2_q;

  ram_store #(
    .WORDS(RAM_WORDS),
    .AW(7)
  ) u_ram (
    .clk_in(clk_in),
    .we_in(ram_we),
    .addr_in(addr_q[6:0]),
    .wdata_in(wd_q),
    .rdata_out(ram_rd)
  );

  // Registered read data, zero unless RAM read hit
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rdata_out <= 8'h00;
    end else begin
      rdata_out <= (hit_q && rw_q) ? ram_rd : 8'h00;
    end
  end

  // Outputs straight from registers
  assign bus_clk_out = bus_clk_q;
  assign addr_out = addr_q;
  assign rw_out = rw_q;
  assign mem_access_out = acc_q;
  assign ram_hit_out = hit_q;
  assign data_drive_n_out = drv_n_q;
  assign temp_addr_out = temp_q;
  assign cycle_end_out = end_q;

  // Assertions
  sequence s_stretch;
    bus_clk_q && tick_q == 2'h3 && !hold_s2_q;
  endsequence

  // A cycle with hold high at its last high tick lasts exactly four ticks
  AST_DIV4: assert property (@(posedge clk_in) disable iff (rst_in)
    (end_q ##3 (hold_s2_q && tick_q == 2'h3)) |=> end_q)
    else $error("bus clock not divide by four");
  AST_STRETCH: assert property (@(posedge clk_in) disable iff (rst_in)
    s_stretch |=> bus_clk_q && tick_q == 2'h2)
    else $error("stretch not a half period");
  AST_HIGH_PHASE: assert property (@(posedge clk_in) disable iff (rst_in)
    $rose(bus_clk_q) |-> bus_clk_q [*2])
    else $error("high phase too short");
  AST_STABLE: assert property (@(posedge clk_in) disable iff (rst_in)
    !end_q |=> $stable(addr_q) && $stable(rw_q))
    else $error("address moved mid cycle");
  AST_RAM_GATE: assert property (@(posedge clk_in) disable iff (rst_in)
    ram_we |-> rsel_s2_q && addr_q <= RAM_TOP_ADDR)
    else $error("RAM written while deselected");
  AST_DRIVE: assert property (@(posedge clk_in) disable iff (rst_in)
    !drv_n_q |-> hit_q && rw_q)
    else $error("data driven without RAM read");
  AST_DIRECT: assert property (@(posedge clk_in) disable iff (rst_in)
    (end_q && req_in && mode_in == 3'b010) |=> addr_q[15:8] == 8'h00)
    else $error("direct upper byte not zero");
  AST_EXT: assert property (@(posedge clk_in) disable iff (rst_in)
    (end_q && req_in && mode_in == 3'b011)
      |=> addr_q == {$past(byte2_in), $past(byte3_in)})
    else $error("extended address wrong");
  AST_REL: assert property (@(posedge clk_in) disable iff (rst_in)
    (end_q && req_in && mode_in == 3'b110)
      |=> addr_q == $past(pc_in) + 16'h0002
          + {{8{$past(byte2_in[7])}}, $past(byte2_in)})
    else $error("relative address wrong");
  AST_NOADDR: assert property (@(posedge clk_in) disable iff (rst_in)
    (end_q && req_in && (mode_in == 3'b000 || mode_in == 3'b101))
      |=> !acc_q)
    else $error("register mode made an access");
endmodule

//--- dv/mem_partner.sv
// Slow external memory that asks for bus clock stretching
`timescale 1ns/1ps
module mem_partner (
  input wire logic clk_in,
  input wire logic slow_in,
  input wire logic bus_clk_in,
  output logic slow_memory_hold_input
);
  // Previous bus clock level, to find its falling tick
  logic bus_q = 1'b0;
  initial slow_memory_hold_input = 1'b1;
  // One low tick per bus cycle keeps each stretch to one half period
  // Pulsing just after the fall lets it clear the two-flop delay in time
  always @(posedge clk_in) begin
    bus_q <= bus_clk_in;
    slow_memory_hold_input <= #1 !(slow_in && !bus_clk_in && bus_q);
  end
endmodule

//--- dv/bus_front_tb_top.sv
// Self-checking bench for the bus front end
`timescale 1ns/1ps
module bus_front_tb_top;
  import bus_front_pkg::*;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic ram_select_input = 1'b0;
  logic req_in = 1'b0;
  logic [2:0] mode_in = 3'h0;
  logic [7:0] byte2_in = 8'h00;
  logic [7:0] byte3_in = 8'h00;
  logic [15:0] pc_in = 16'h0000;
  logic [15:0] index_in = 16'h0000;
  logic rw_in = 1'b1;
  logic [7:0] wdata_in = 8'h00;
  logic slow_q = 1'b0;
  logic slow_memory_hold_input, bus_clk_out, rw_out, mem_access_out;
  logic ram_hit_out, data_drive_n_out, cycle_end_out;
  logic [15:0] addr_out, temp_addr_out, ea;
  logic [7:0] rdata_out;
  logic [7:0] ram_model [128];
  bit known [128];
  int n_mismatch = 0;
  int comparisons = 0;
  int seed = 63;
  int ticks = 0;
  int run_len = 0;
  int last_len = 0;
  bus_front uut (.clk_in(clk_in), .rst_in(rst_in),
    .slow_memory_hold_input(slow_memory_hold_input),
    .ram_select_input(ram_select_input), .req_in(req_in),
    .mode_in(mode_in), .byte2_in(byte2_in), .byte3_in(byte3_in),
    .pc_in(pc_in), .index_in(index_in), .rw_in(rw_in),
    .wdata_in(wdata_in), .bus_clk_out(bus_clk_out), .addr_out(addr_out),
    .rw_out(rw_out), .mem_access_out(mem_access_out),
    .ram_hit_out(ram_hit_out), .data_drive_n_out(data_drive_n_out),
    .rdata_out(rdata_out), .temp_addr_out(temp_addr_out),
    .cycle_end_out(cycle_end_out));
  mem_partner partner (.clk_in(clk_in), .slow_in(slow_q),
    .bus_clk_in(bus_clk_out),
    .slow_memory_hold_input(slow_memory_hold_input));
  // Oscillator-rate clock, 25 ns period
  initial forever #12.5 clk_in = ~clk_in;
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Bus cycle length between cycle-end pulses, plus hang guard
  // Sampled on the falling edge, away from the launching edge
  always @(negedge clk_in) begin
    ticks++;
    run_len++;
    if (cycle_end_out === 1'b1) begin
      last_len = run_len;
      run_len = 0;
    end
    if (ticks > 20000) begin
      n_mismatch++;
      close_out();
    end
  end
  // One operand request, checked against the reference address model
  task automatic op(input logic [2:0] m, input logic r);
    logic acc;
    logic hit;
    int i;
    mode_in = m;
    rw_in = r;
    byte2_in = $random(seed);
    byte3_in = $random(seed);
    pc_in = $random(seed);
    index_in = $random(seed);
    wdata_in = $random(seed);
    req_in = 1'b1;
    acc = !(m == MODE_ACCUM || m == MODE_IMPLIED);
    case (m)
      MODE_IMMED: ea = pc_in + 16'h0001;
      MODE_DIRECT: ea = {8'h00, byte2_in};
      MODE_EXTEND: ea = {byte2_in, byte3_in};
      MODE_INDEX: ea = index_in + {8'h00, byte2_in};
      default: ea = pc_in + 16'h0002 + {{8{byte2_in[7]}}, byte2_in};
    endcase
    hit = acc && ea <= RAM_TOP_ADDR && ram_select_input;
    for (i = 0; i < 40 && cycle_end_out !== 1'b1; i++) @(posedge clk_in) #1;
    @(posedge clk_in) #1;
    chk(bus_clk_out, 1'b0);
    @(posedge clk_in) #1;
    chk(bus_clk_out, 1'b1);
    chk(mem_access_out, acc);
    if (acc) begin
      chk(addr_out, ea);
      chk(rw_out, r);
      chk(ram_hit_out, hit);
      chk(data_drive_n_out, !(hit && r));
      if (m == MODE_INDEX) chk(temp_addr_out, ea);
      repeat (2) @(posedge clk_in);
      #1;
      if (r && !hit) chk(rdata_out, 16'h0000);
      if (r && hit && known[ea[6:0]]) chk(rdata_out, ram_model[ea[6:0]]);
      if (!r && hit) begin
        ram_model[ea[6:0]] = wdata_in;
        known[ea[6:0]] = 1'b1;
      end
    end
  endtask
  // Reset, then sweep select and stretch settings with random traffic
  initial begin
    int s;
    int i;
    repeat (5) @(posedge clk_in);
    #1;
    chk(addr_out, ADDR_RST);
    chk(rw_out, 1'b1);
    rst_in = 1'b0;
    for (s = 0; s < 8; s++) begin
      ram_select_input = s[0];
      slow_q = s[1];
      repeat (4) @(posedge clk_in);
      #1;
      for (i = 0; i < 40; i++) begin
        op(($random(seed) & 1) ? MODE_DIRECT : 3'($unsigned($random(seed)) % 7),
          1'($random(seed)));
        if (i > 2 && !slow_q) chk(last_len, OSC_PER_BUS);
        if (i > 2 && slow_q)
          chk(last_len, OSC_PER_BUS + OSC_PER_BUS / 2);
      end
    end
    close_out();
  end
endmodule
